// >>> design/adcc_cfg.svh
// Constants of the digital comparator selection and status block.
// Assumes a 32-bit AXI4-Lite register port and a converter core on the same clock.
`ifndef ADCC_CFG_SVH
`define ADCC_CFG_SVH

`define ADCC_ADDR_W        8
`define ADCC_OFF_MODE      8'h00
`define ADCC_OFF_ENABLE    8'h04
`define ADCC_OFF_CTRL      8'h08
`define ADCC_OFF_LIMITS    8'h0c
`define ADCC_OFF_IRQ_STAT  8'h10
`define ADCC_OFF_IRQ_MASK  8'h14

`define ADCC_MODE_DIFF_BIT 1
`define ADCC_MODE_SIGN_BIT 0

`define ADCC_CVD_MSB       31
`define ADCC_CVD_LSB       16
`define ADCC_ID_MSB        13
`define ADCC_ID_LSB        8
`define ADCC_CTL_EN_BIT    7
`define ADCC_CTL_GIE_BIT   6
`define ADCC_CTL_FLAG_BIT  5
`define ADCC_CTL_BTWN_BIT  4
`define ADCC_CTL_HIHI_BIT  3
`define ADCC_CTL_HILO_BIT  2
`define ADCC_CTL_LOHI_BIT  1
`define ADCC_CTL_LOLO_BIT  0

`define ADCC_NUM_CMP_IN    32
`define ADCC_ZERO32        32'h0000_0000
`define ADCC_RESP_OKAY     2'h0
`define ADCC_RESP_SLVERR   2'h2

`endif

// >>> design/adcc_pkg.sv
// Types shared by the comparator selection block and its register port.
// Assumes the constants header is included by the users of these types.
package adcc_pkg;
    typedef logic [5:0]  adcc_input_id_t;
    typedef logic [31:0] adcc_word_t;
    typedef logic [1:0]  adcc_resp_t;
endpackage : adcc_pkg

// >>> design/adcc_reg_if.sv
// Register access strobes between the bus slave and the register file.
// Assumes both ends run on one clock; strobes last one cycle.
`timescale 1ns/100ps
interface adcc_reg_if;
    logic                    wr_en;
    logic [7:0]              wr_addr;
    adcc_pkg::adcc_word_t    wr_data;
    logic [3:0]              wr_strb;
    logic                    wr_hit;
    logic                    rd_en;
    logic [7:0]              rd_addr;
    adcc_pkg::adcc_word_t    rd_data;
    logic                    rd_hit;
    modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                 input wr_hit, rd_data, rd_hit);
    modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                  output wr_hit, rd_data, rd_hit);
endinterface : adcc_reg_if

// >>> design/adcc_axil.sv
// AXI4-Lite slave that turns bus transfers into one-cycle register strobes.
// Assumes the register file answers rd_data and hits combinationally.
`timescale 1ns/100ps
`include "adcc_cfg.svh"
module adcc_axil (
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic [7:0]  awaddr_i,
    input  wire logic        awvalid_i,
    output logic             awready_o,
    input  wire logic [31:0] wdata_i,
    input  wire logic [3:0]  wstrb_i,
    input  wire logic        wvalid_i,
    output logic             wready_o,
    output logic [1:0]       bresp_o,
    output logic             bvalid_o,
    input  wire logic        bready_i,
    input  wire logic [7:0]  araddr_i,
    input  wire logic        arvalid_i,
    output logic             arready_o,
    output logic [31:0]      rdata_o,
    output logic [1:0]       rresp_o,
    output logic             rvalid_o,
    input  wire logic        rready_i,
    adcc_reg_if.bus          rif
);
    logic       aw_have_q, aw_have_d;
    logic       w_have_q, w_have_d;
    logic       bvalid_d;
    logic       ar_have_q, ar_have_d;
    logic       rvalid_d;
    logic [7:0] awaddr_q;
    logic [7:0] araddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic       wr_go;
    logic       rd_go;

    // The write fires only once both halves are held, so either order works.
    assign wr_go = aw_have_q && w_have_q && !bvalid_o;
    assign rd_go = ar_have_q && !rvalid_o;

    always_comb begin
        aw_have_d = aw_have_q;
        w_have_d  = w_have_q;
        bvalid_d  = bvalid_o;
        if (awvalid_i && awready_o) begin
            aw_have_d = 1'b1;
        end
        if (wvalid_i && wready_o) begin
            w_have_d = 1'b1;
        end
        if (wr_go) begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
        end else if (bvalid_o && bready_i) begin
            bvalid_d = 1'b0;
        end
    end

    always_comb begin
        ar_have_d = ar_have_q;
        rvalid_d  = rvalid_o;
        if (arvalid_i && arready_o) begin
            ar_have_d = 1'b1;
        end
        if (rd_go) begin
            ar_have_d = 1'b0;
            rvalid_d  = 1'b1;
        end else if (rvalid_o && rready_i) begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            bvalid_o  <= 1'b0;
            awready_o <= 1'b0;
            wready_o  <= 1'b0;
            bresp_o   <= `ADCC_RESP_OKAY;
            awaddr_q  <= 8'h00;
            wdata_q   <= `ADCC_ZERO32;
            wstrb_q   <= 4'h0;
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q  <= w_have_d;
            bvalid_o  <= bvalid_d;
            awready_o <= !aw_have_d && !bvalid_d;
            wready_o  <= !w_have_d && !bvalid_d;
            if (awvalid_i && awready_o) begin
                awaddr_q <= awaddr_i;
            end
            if (wvalid_i && wready_o) begin
                wdata_q <= wdata_i;
                wstrb_q <= wstrb_i;
            end
            if (wr_go) begin
                bresp_o <= rif.wr_hit ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            ar_have_q <= 1'b0;
            rvalid_o  <= 1'b0;
            arready_o <= 1'b0;
            araddr_q  <= 8'h00;
            rdata_o   <= `ADCC_ZERO32;
            rresp_o   <= `ADCC_RESP_OKAY;
        end else begin
            ar_have_q <= ar_have_d;
            rvalid_o  <= rvalid_d;
            arready_o <= !ar_have_d && !rvalid_d;
            if (arvalid_i && arready_o) begin
                araddr_q <= araddr_i;
            end
            if (rd_go) begin
                rdata_o <= rif.rd_hit ? rif.rd_data : `ADCC_ZERO32;
                rresp_o <= rif.rd_hit ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
            end
        end
    end

    assign rif.wr_en   = wr_go;
    assign rif.wr_addr = awaddr_q;
    assign rif.wr_data = wdata_q;
    assign rif.wr_strb = wstrb_q;
    assign rif.rd_en   = rd_go;
    assign rif.rd_addr = araddr_q;
endmodule : adcc_axil

// >>> design/adcc_top.sv
// Digital comparator input selection, input 32 mode bits and event status.
// Assumes conversion results arrive from the converter core on clk_i, one per valid cycle.
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "adcc_cfg.svh"
module adcc_top (
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic [7:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [7:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    input  wire logic        res_valid_i,
    input  wire logic        res_cvd_i,
    input  wire logic [5:0]  res_input_i,
    input  wire logic [31:0] res_data_i,
    input  wire logic [15:0] res_cvd_pos_i,
    input  wire logic [15:0] res_cvd_neg_i,
    output logic             input32_differential_select_o,
    output logic             input32_signed_select_o,
    output logic             comparator_event_flag_o,
    output logic             irq_o
);
    adcc_reg_if rif ();

    adcc_axil u_axil (
        .clk_i     (clk_i),
        .rst_b_i   (rst_b_i),
        .awaddr_i  (s_axi_awaddr_i),
        .awvalid_i (s_axi_awvalid_i),
        .awready_o (s_axi_awready_o),
        .wdata_i   (s_axi_wdata_i),
        .wstrb_i   (s_axi_wstrb_i),
        .wvalid_i  (s_axi_wvalid_i),
        .wready_o  (s_axi_wready_o),
        .bresp_o   (s_axi_bresp_o),
        .bvalid_o  (s_axi_bvalid_o),
        .bready_i  (s_axi_bready_i),
        .araddr_i  (s_axi_araddr_i),
        .arvalid_i (s_axi_arvalid_i),
        .arready_o (s_axi_arready_o),
        .rdata_o   (s_axi_rdata_o),
        .rresp_o   (s_axi_rresp_o),
        .rvalid_o  (s_axi_rvalid_o),
        .rready_i  (s_axi_rready_i),
        .rif       (rif)
    );

    adcc_pkg::adcc_word_t     wmask;
    adcc_pkg::adcc_word_t     mode_q;
    adcc_pkg::adcc_word_t     enable_q;
    adcc_pkg::adcc_word_t     limits_q;
    logic [4:0]               cond_q;
    logic                     cmp_en_q;
    logic                     gie_q;
    logic                     flag_q;
    adcc_pkg::adcc_input_id_t id_q;
    logic [15:0]              cvd_q;
    logic                     irq_stat_q;
    logic                     irq_mask_q;
    logic                     wr_mode, wr_enable, wr_ctrl, wr_limits, wr_stat, wr_mask;
    logic                     rd_ctrl;
    logic                     selected;
    logic                     cond_true;
    logic                     evt;
    logic signed [31:0]       sample;
    logic signed [31:0]       lo_lim;
    logic signed [31:0]       hi_lim;
    logic [15:0]              cvd_diff;
    logic                     ctrl_en_new;

    // Byte lanes follow wstrb so partial writes leave other lanes intact.
    for (genvar b = 0; b < 4; b++) begin : g_lane
        assign wmask[8*b +: 8] = {8{rif.wr_strb[b]}};
    end

    assign wr_mode   = rif.wr_en && (rif.wr_addr == `ADCC_OFF_MODE);
    assign wr_enable = rif.wr_en && (rif.wr_addr == `ADCC_OFF_ENABLE);
    assign wr_ctrl   = rif.wr_en && (rif.wr_addr == `ADCC_OFF_CTRL);
    assign wr_limits = rif.wr_en && (rif.wr_addr == `ADCC_OFF_LIMITS);
    assign wr_stat   = rif.wr_en && (rif.wr_addr == `ADCC_OFF_IRQ_STAT);
    assign wr_mask   = rif.wr_en && (rif.wr_addr == `ADCC_OFF_IRQ_MASK);
    assign rd_ctrl   = rif.rd_en && (rif.rd_addr == `ADCC_OFF_CTRL);

    assign rif.wr_hit = wr_mode || wr_enable || wr_ctrl || wr_limits || wr_stat || wr_mask;

    always_comb begin
        rif.rd_hit  = 1'b1;
        rif.rd_data = `ADCC_ZERO32;
        unique case (rif.rd_addr)
            `ADCC_OFF_MODE: begin
                rif.rd_data[`ADCC_MODE_DIFF_BIT] = mode_q[`ADCC_MODE_DIFF_BIT];
                rif.rd_data[`ADCC_MODE_SIGN_BIT] = mode_q[`ADCC_MODE_SIGN_BIT];
            end
            `ADCC_OFF_ENABLE: rif.rd_data = enable_q;
            `ADCC_OFF_CTRL: begin
                rif.rd_data[`ADCC_CVD_MSB:`ADCC_CVD_LSB]   = cvd_q;
                rif.rd_data[`ADCC_ID_MSB:`ADCC_ID_LSB]     = id_q;
                rif.rd_data[`ADCC_CTL_EN_BIT]              = cmp_en_q;
                rif.rd_data[`ADCC_CTL_GIE_BIT]             = gie_q;
                rif.rd_data[`ADCC_CTL_FLAG_BIT]            = flag_q;
                rif.rd_data[`ADCC_CTL_BTWN_BIT:`ADCC_CTL_LOLO_BIT] = cond_q;
            end
            `ADCC_OFF_LIMITS:   rif.rd_data = limits_q;
            `ADCC_OFF_IRQ_STAT: rif.rd_data[0] = irq_stat_q;
            `ADCC_OFF_IRQ_MASK: rif.rd_data[0] = irq_mask_q;
            default:            rif.rd_hit = 1'b0;
        endcase
    end

    // Enable bits are used live, not shadowed; changing them mid-compare is unsafe.
    assign selected = res_cvd_i ||
                      ((res_input_i < 6'(`ADCC_NUM_CMP_IN)) &&
                       enable_q[res_input_i[4:0]]);

    assign cvd_diff = res_cvd_pos_i - res_cvd_neg_i;
    assign sample   = res_cvd_i ? {{16{cvd_diff[15]}}, cvd_diff} : res_data_i;
    assign lo_lim   = {{16{limits_q[15]}}, limits_q[15:0]};
    assign hi_lim   = {{16{limits_q[31]}}, limits_q[31:16]};

    always_comb begin
        cond_true = 1'b0;
        if (cond_q[`ADCC_CTL_BTWN_BIT] && (sample >= lo_lim) && (sample < hi_lim)) begin
            cond_true = 1'b1;
        end
        if (cond_q[`ADCC_CTL_HIHI_BIT] && (sample >= hi_lim)) begin
            cond_true = 1'b1;
        end
        if (cond_q[`ADCC_CTL_HILO_BIT] && (sample < hi_lim)) begin
            cond_true = 1'b1;
        end
        if (cond_q[`ADCC_CTL_LOHI_BIT] && (sample >= lo_lim)) begin
            cond_true = 1'b1;
        end
        if (cond_q[`ADCC_CTL_LOLO_BIT] && (sample < lo_lim)) begin
            cond_true = 1'b1;
        end
    end

    assign evt         = res_valid_i && cmp_en_q && selected && cond_true;
    assign ctrl_en_new = (rif.wr_data[`ADCC_CTL_EN_BIT] && wmask[`ADCC_CTL_EN_BIT]) ||
                         (cmp_en_q && !wmask[`ADCC_CTL_EN_BIT]);

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            mode_q   <= `ADCC_ZERO32;
            enable_q <= `ADCC_ZERO32;
            limits_q <= `ADCC_ZERO32;
        end else begin
            if (wr_mode) begin
                mode_q <= (mode_q & ~wmask) | (rif.wr_data & wmask);
            end
            if (wr_enable) begin
                enable_q <= (enable_q & ~wmask) | (rif.wr_data & wmask);
            end
            if (wr_limits) begin
                limits_q <= (limits_q & ~wmask) | (rif.wr_data & wmask);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            input32_differential_select_o <= 1'b0;
            input32_signed_select_o       <= 1'b0;
        end else begin
            input32_differential_select_o <= mode_q[`ADCC_MODE_DIFF_BIT];
            input32_signed_select_o       <= mode_q[`ADCC_MODE_SIGN_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            cond_q   <= 5'h00;
            cmp_en_q <= 1'b0;
            gie_q    <= 1'b0;
        end else if (wr_ctrl) begin
            cmp_en_q <= ctrl_en_new;
            if (wmask[`ADCC_CTL_GIE_BIT]) begin
                gie_q <= rif.wr_data[`ADCC_CTL_GIE_BIT];
            end
            if (wmask[`ADCC_CTL_LOLO_BIT]) begin
                cond_q <= rif.wr_data[`ADCC_CTL_BTWN_BIT:`ADCC_CTL_LOLO_BIT];
            end
        end
    end

    // A new event in the clearing cycle keeps the flag set.
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            flag_q <= 1'b0;
        end else if (evt) begin
            flag_q <= 1'b1;
        end else if (rd_ctrl || (wr_ctrl && !ctrl_en_new)) begin
            flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            id_q  <= 6'h00;
            cvd_q <= 16'h0000;
        end else if (evt) begin
            id_q <= res_input_i;
            if (res_cvd_i) begin
                cvd_q <= cvd_diff;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            irq_stat_q <= 1'b0;
            irq_mask_q <= 1'b0;
        end else begin
            if (evt && gie_q) begin
                irq_stat_q <= 1'b1;
            end else if (wr_stat && rif.wr_strb[0] && rif.wr_data[0]) begin
                irq_stat_q <= 1'b0;
            end
            if (wr_mask && rif.wr_strb[0]) begin
                irq_mask_q <= rif.wr_data[0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            irq_o                   <= 1'b0;
            comparator_event_flag_o <= 1'b0;
        end else begin
            irq_o                   <= irq_stat_q && irq_mask_q;
            comparator_event_flag_o <= flag_q;
        end
    end
endmodule : adcc_top

// >>> testbench/adcc_check_monitor.sv
// Assertions on the top ports of the comparator selection block.
// Assumes writes offer address and data together with full strobes.
`timescale 1ns/100ps
module adcc_check (
    input wire logic        clk_i,
    input wire logic        rst_b_i,
    input wire logic [7:0]  s_axi_awaddr_i,
    input wire logic        s_axi_awvalid_i,
    input wire logic        s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic        s_axi_wvalid_i,
    input wire logic        s_axi_wready_o,
    input wire logic        s_axi_bvalid_o,
    input wire logic        s_axi_bready_i,
    input wire logic [7:0]  s_axi_araddr_i,
    input wire logic        s_axi_arvalid_i,
    input wire logic        s_axi_arready_o,
    input wire logic        s_axi_rvalid_o,
    input wire logic        s_axi_rready_i,
    input wire logic        res_valid_i,
    input wire logic        res_cvd_i,
    input wire logic [5:0]  res_input_i,
    input wire logic        input32_differential_select_o,
    input wire logic        input32_signed_select_o,
    input wire logic        comparator_event_flag_o
);
    logic [7:0]  wa_q;
    logic [7:0]  ra_q;
    logic [31:0] wd_q;
    logic [31:0] en_q;
    logic [1:0]  mode_q;
    logic        on_q;
    always_ff @(posedge clk_i) begin
        if (s_axi_awvalid_i && s_axi_awready_o) wa_q <= s_axi_awaddr_i;
        if (s_axi_wvalid_i && s_axi_wready_o) wd_q <= s_axi_wdata_i;
        if (s_axi_arvalid_i && s_axi_arready_o) ra_q <= s_axi_araddr_i;
    end
    // Shadows follow the response, so they lag the register by design.
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            en_q <= 32'h0000_0000;
            mode_q <= 2'h0;
            on_q <= 1'b0;
        end else if (s_axi_bvalid_o && s_axi_bready_i) begin
            if (wa_q == 8'h00) mode_q <= wd_q[1:0];
            if (wa_q == 8'h04) en_q <= wd_q;
            if (wa_q == 8'h08) on_q <= wd_q[7];
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence mode_written;
        $rose(s_axi_bvalid_o) && wa_q == 8'h00;
    endsequence
    sequence ctrl_read;
        s_axi_rvalid_o && s_axi_rready_i && ra_q == 8'h08 && !res_valid_i;
    endsequence
    property quiet_result(bad);
        !comparator_event_flag_o && !$past(res_valid_i) && res_valid_i && bad
        ##1 !res_valid_i && !comparator_event_flag_o |-> ##1 !comparator_event_flag_o;
    endproperty
    AST_DIFF_PIN: assert property (
        mode_written |-> ##1 (input32_differential_select_o == mode_q[1]) [*2])
        else $error("differential pin wrong");
    AST_SIGN_PIN: assert property (
        mode_written |-> ##1 (input32_signed_select_o == mode_q[0]) [*2])
        else $error("signed pin wrong");
    AST_READ_CLEARS: assert property (ctrl_read |-> ##2 !comparator_event_flag_o)
        else $error("flag kept after status read");
    AST_OFF_CLEARS: assert property (
        $rose(s_axi_bvalid_o) && wa_q == 8'h08 && !wd_q[7] && !$past(res_valid_i)
        |-> ##2 !comparator_event_flag_o)
        else $error("flag kept after disable");
    AST_FLAG_CAUSE: assert property (
        $rose(comparator_event_flag_o) |-> $past(res_valid_i, 2) && on_q)
        else $error("flag set without a result");
    AST_QUIET_HIGH: assert property (quiet_result(!res_cvd_i && res_input_i[5]))
        else $error("event from input above 31");
    AST_QUIET_MASKED: assert property (
        quiet_result(!res_cvd_i && !res_input_i[5] && !en_q[res_input_i[4:0]]))
        else $error("event from disabled input");
    AST_QUIET_OFF: assert property (quiet_result(!on_q))
        else $error("event while comparator off");
endmodule : adcc_check
bind adcc_top adcc_check adcc_check_inst (.*);

// >>> testbench/adcc_conv_model.sv
// Behavioural converter core that hands results to the comparator block.
// Assumes convert is called just after a rising clock edge.
`timescale 1ns/100ps
module adcc_conv_model (
    input  wire logic   clk_i,
    output logic        res_valid_o,
    output logic        res_cvd_o,
    output logic [5:0]  res_input_o,
    output logic [31:0] res_data_o,
    output logic [15:0] res_cvd_pos_o,
    output logic [15:0] res_cvd_neg_o
);
    // The core counts as calibrated before it is enabled, so it is silent until the first call.
    initial begin
        res_valid_o = 1'b0;
        res_cvd_o = 1'b1;
        res_input_o = 6'h2a;
        res_data_o = 32'h5a5a_5a5a;
        res_cvd_pos_o = 16'ha5a5;
        res_cvd_neg_o = 16'h5a5a;
    end
    // A gap of zero answers at once; a longer gap models a slow conversion.
    task automatic convert(input logic cvd, input logic [5:0] id, input logic [31:0] d,
                           input logic [15:0] pos, input logic [15:0] neg, input int gap);
        repeat (gap) @(posedge clk_i);
        res_valid_o <= 1'b1;
        res_cvd_o <= cvd;
        res_input_o <= id;
        res_data_o <= d;
        res_cvd_pos_o <= pos;
        res_cvd_neg_o <= neg;
        @(posedge clk_i);
        // No result stands outside the valid cycle, so the lines show the inverse.
        res_valid_o <= 1'b0;
        res_cvd_o <= ~cvd;
        res_input_o <= ~id;
        res_data_o <= ~d;
        res_cvd_pos_o <= ~pos;
        res_cvd_neg_o <= ~neg;
    endtask : convert
endmodule : adcc_conv_model

// >>> testbench/testbench.sv
// Self-checking bench: register traffic over AXI4-Lite, results from the core model.
// Assumes every bus transfer is answered well within the cycle ceiling.
`timescale 1ns/100ps
module testbench;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    // Both response readies stay high, so back-to-back calls never drive them twice in a step.
    logic        bready = 1'b1;
    logic        arvalid = 1'b0;
    logic        rready = 1'b1;
    logic        awready, wready, bvalid, arready, rvalid, rv, rc, diff, sign, flag, irq;
    logic [1:0]  bresp, rresp, resp;
    logic [5:0]  ri;
    logic [15:0] rp, rn;
    logic [31:0] rdata, rdd, rd;
    logic [5:0]  ids [2] = '{6'd0, 6'd31};
    int          n_errors = 0;
    int          checks = 0;
    int          cycles = 0;
    always #25 clk = ~clk;
    adcc_conv_model adcc_conv_model_inst (.clk_i(clk), .res_valid_o(rv), .res_cvd_o(rc),
        .res_input_o(ri), .res_data_o(rdd), .res_cvd_pos_o(rp), .res_cvd_neg_o(rn));
    adcc_top adcc_top_inst (.clk_i(clk), .rst_b_i(rst_b), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .res_valid_i(rv), .res_cvd_i(rc), .res_input_i(ri),
        .res_data_i(rdd), .res_cvd_pos_i(rp), .res_cvd_neg_i(rn),
        .input32_differential_select_o(diff), .input32_signed_select_o(sign),
        .comparator_event_flag_o(flag), .irq_o(irq));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic print_verdict;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
    endtask : axi_write
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
    endtask : axi_read
    // The flag shows one edge after the result edge, so three edges always suffice.
    task automatic send(input logic cvd, input logic [5:0] id, input logic [31:0] d,
                        input logic [15:0] pos, input logic [15:0] neg, input int gap);
        adcc_conv_model_inst.convert(cvd, id, d, pos, neg, gap);
        repeat (3) @(posedge clk);
    endtask : send
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            print_verdict();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        for (int a = 0; a < 12; a += 4) begin
            axi_read(8'(a), rd, resp);
            check("reset value", rd, 32'h0000_0000);
        end
        axi_read(8'h20, rd, resp);
        check("unmapped read", {rd[29:0], resp}, 32'h0000_0002);
        axi_write(8'h20, 32'hffff_ffff, resp);
        check("unmapped write", {30'h0, resp}, 32'h0000_0002);
        for (int m = 0; m < 4; m++) begin
            axi_write(8'h00, 32'(m), resp);
            axi_read(8'h00, rd, resp);
            check("mode reg", rd, 32'(m));
            check("diff pin", {31'h0, diff}, {31'h0, m[1]});
            check("sign pin", {31'h0, sign}, {31'h0, m[0]});
        end
        axi_write(8'h0c, 32'h0100_0000, resp);
        axi_write(8'h14, 32'h0000_0001, resp);
        foreach (ids[k]) begin
            axi_write(8'h08, 32'h0000_0000, resp);
            axi_write(8'h04, 32'h0000_0001 << ids[k], resp);
            axi_write(8'h08, 32'h0000_00c8, resp);
            send(1'b0, ids[k] ^ 6'h01, 32'h0000_0200, 16'h0000, 16'h0000, 0);
            check("flag off input", {31'h0, flag}, 32'h0000_0000);
            send(1'b0, ids[k] + 6'd32, 32'h0000_0200, 16'h0000, 16'h0000, 2);
            check("flag high input", {31'h0, flag}, 32'h0000_0000);
            send(1'b0, ids[k], 32'h0000_00ff, 16'h0000, 16'h0000, 4);
            check("flag below", {31'h0, flag}, 32'h0000_0000);
            send(1'b0, ids[k], 32'h0000_0100, 16'h0000, 16'h0000, 0);
            check("flag at limit", {31'h0, flag}, 32'h0000_0001);
            axi_read(8'h08, rd, resp);
            check("event id", {26'h0, rd[13:8]}, {26'h0, ids[k]});
            repeat (2) @(posedge clk);
            check("flag after read", {31'h0, flag}, 32'h0000_0000);
            check("irq held", {31'h0, irq}, 32'h0000_0001);
            axi_write(8'h10, 32'h0000_0001, resp);
            repeat (2) @(posedge clk);
            check("irq cleared", {31'h0, irq}, 32'h0000_0000);
        end
        axi_write(8'h14, 32'h0000_0000, resp);
        send(1'b0, 6'd31, 32'h7fff_ffff, 16'h0000, 16'h0000, 1);
        check("masked irq", {31'h0, irq}, 32'h0000_0000);
        axi_read(8'h10, rd, resp);
        check("irq status", rd, 32'h0000_0001);
        axi_write(8'h08, 32'h0000_0048, resp);
        repeat (2) @(posedge clk);
        check("flag after disable", {31'h0, flag}, 32'h0000_0000);
        send(1'b0, 6'd31, 32'h0000_0200, 16'h0000, 16'h0000, 0);
        check("flag while off", {31'h0, flag}, 32'h0000_0000);
        axi_write(8'h10, 32'h0000_0001, resp);
        axi_read(8'h10, rd, resp);
        check("irq status clear", rd, 32'h0000_0000);
        // The difference is negative, so the below-low condition must be on to raise an event.
        axi_write(8'h08, 32'h0000_00c9, resp);
        send(1'b1, 6'd40, 32'h0000_0200, 16'h0010, 16'h0030, 1);
        axi_read(8'h08, rd, resp);
        check("cvd difference", {16'h0, rd[31:16]}, 32'h0000_ffe0);
        check("cvd id", {26'h0, rd[13:8]}, 32'h0000_0028);
        print_verdict();
    end
endmodule : testbench
